// [inc/sia_pkg.sv]
// Constants for the serial port, interrupt and timer A control block.
// Assumes an 8-bit register port with a 4-bit register index.
package sia_pkg;

   // Register indices
   localparam logic [3:0] SIA_SDR_OFFSET    = 4'hc;
   localparam logic [3:0] SIA_ISM_OFFSET    = 4'hd;
   localparam logic [3:0] SIA_CTRL_OFFSET   = 4'he;

   // Interrupt status bit positions
   localparam int SIA_SRC_TIMER_A = 0;
   localparam int SIA_SRC_TIMER_B = 1;
   localparam int SIA_SRC_ALARM   = 2;
   localparam int SIA_SRC_SERIAL  = 3;
   localparam int SIA_SRC_FLAG    = 4;
   localparam int SIA_NUM_SRC     = 5;
   localparam int SIA_ISM_SC_BIT  = 7;
   localparam int SIA_ISM_IR_BIT  = 7;

   // Timer A control bit positions
   localparam int SIA_CTRL_START  = 0;
   localparam int SIA_CTRL_ROUTE  = 1;
   localparam int SIA_CTRL_STYLE  = 2;
   localparam int SIA_CTRL_RUN    = 3;
   localparam int SIA_CTRL_LOAD   = 4;
   localparam int SIA_CTRL_CSRC   = 5;
   localparam int SIA_CTRL_DIR    = 6;
   // Bits that hold state; load strobe and bit 7 never store
   localparam logic [7:0] SIA_CTRL_STORE_MASK = 8'h6f;

   // Reset values
   localparam logic [7:0] SIA_CTRL_RESET = 8'h00;
   localparam logic [4:0] SIA_MASK_RESET = 5'h00;
   localparam logic [4:0] SIA_STAT_RESET = 5'h00;
   localparam logic [7:0] SIA_SDR_RESET  = 8'h00;

   // Serial framing
   localparam int         SIA_BYTE_BITS  = 8;
   localparam logic [3:0] SIA_LAST_BIT   = 4'h7;
   // Shortest half period of the shift clock: two core cycles gives core/4
   localparam int         SIA_HALF_MIN   = 2;
   localparam logic [1:0] SIA_GAP_RELOAD = 2'(SIA_HALF_MIN - 1);

endpackage : sia_pkg

// [core/sia_ctrl.sv]
// Interrupt status and mask, serial shift port and timer A control register.
// Assumes an external timer A counter that gives underflow pulses on i_core_clk,
// and external wiring that resolves the two open-drain serial pins.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Output shift clock toggles per timer A underflow
// - Shift clock never faster than core clock/4
// - Data write loads shifter, then shifts out
// - Output mode drives shift clock onto pin
// - Bit changes on falling shift clock edge
// - Serial event after eight clock pulses
// - Pending byte reloads with no gap
// - Idle: clock high, data holds last bit
// - Bytes travel most significant bit first
// - Clock and data pins are open drain
// - Five latched sources, bits five-six read zero
// - Events always latch; enabled ones raise request
// - Status read clears bits, releases request
// - Mask write: bit seven picks set/clear
// - Start bit runs timer; one-shot underflow clears
// - Route bit puts timer output on line six
// - Style bit picks toggle or pulse output
// - Run bit picks one-shot or continuous
// - Load bit is a strobe, reads zero
// - Count source: pin rises or core clock
// - Direction bit picks serial output or input
// - Input mode samples on rising clock, eight bits
// - Falling flag pin edge sets flag status
// - Unused control bits ignore writes, read zero
module sia_ctrl
   import sia_pkg::*;
(
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Event sources on the core clock
   input  wire logic       i_timer_a_underflow,
   input  wire logic       i_timer_b_underflow,
   input  wire logic       i_alarm,
   // Edge flag pin, asynchronous
   input  wire logic       i_edge_flag_source,
   // Shift clock pin, open drain
   input  wire logic       i_shift_count_pin,
   output logic            o_shift_count_pin,
   output logic            o_shift_count_pin_oe,
   // Serial data pin, open drain
   input  wire logic       i_serial_data_pin,
   output logic            o_serial_data_pin,
   output logic            o_serial_data_pin_oe,
   // Interrupt request, active low
   output logic            o_irq_n,
   // Timer A controls
   output logic            o_timer_a_run,
   output logic            o_timer_a_one_shot,
   output logic            o_timer_a_force_load,
   output logic            o_timer_a_count_pin,
   output logic            o_timer_a_pin_rise,
   // Port B line six override
   output logic            o_timer_output_route,
   output logic            o_port_b_line_six
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [4:0] status;
      logic [4:0] mask;
      logic       ir;
      logic [7:0] ctrl;
      logic       force_load;
      logic [7:0] serial_data_register;
      logic       pend;
      logic [7:0] shifter;
      logic [3:0] bit_cnt;
      logic       active;
      logic       sclk;
      logic       sdat;
      logic [1:0] gap;
      logic       cnt_s1;
      logic       cnt_s2;
      logic       cnt_prev;
      logic       sp_s1;
      logic       sp_s2;
      logic       flg_s1;
      logic       flg_s2;
      logic       flg_prev;
      logic       tog;
      logic       pulse;
      logic       pin_rise;
      logic [7:0] rdata;
   } sia_state_type;

   sia_state_type s;
   sia_state_type next_s;

   // Register decode, used by both strobes
   function automatic logic sia_hit(input logic [3:0] addr, input logic [3:0] offset);
      sia_hit = (addr == offset);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [4:0] events;
      logic       tx_tick;
      logic       out_mode;
      logic       rx_rise;
      logic       ser_event;
      logic [7:0] rx_byte;
      events    = 5'h00;
      tx_tick   = 1'b0;
      out_mode  = s.ctrl[SIA_CTRL_DIR];
      rx_rise   = 1'b0;
      ser_event = 1'b0;
      rx_byte   = 8'h00;
      next_s    = s;

      // Pin synchronisers; logic reads the second stage and the delayed prev copy, never the first stage
      next_s.cnt_s1   = i_shift_count_pin;
      next_s.cnt_s2   = s.cnt_s1;
      next_s.cnt_prev = s.cnt_s2;
      next_s.sp_s1    = i_serial_data_pin;
      next_s.sp_s2    = s.sp_s1;
      next_s.flg_s1   = i_edge_flag_source;
      next_s.flg_s2   = s.flg_s1;
      next_s.flg_prev = s.flg_s2;

      rx_rise          = s.cnt_s2 & ~s.cnt_prev;
      next_s.pin_rise  = rx_rise;

      // Guard keeps each shift clock half period at least two cycles
      if (s.gap != 2'h0) begin
         next_s.gap = s.gap - 2'h1;
      end
      tx_tick = out_mode & i_timer_a_underflow & (s.gap == 2'h0);

      ////////////////////////////////////////////////////////////////////////
      // Serial port
      if (out_mode) begin
         if (tx_tick) begin
            next_s.gap = SIA_GAP_RELOAD;
         end
         if (!s.active) begin
            if (s.pend && tx_tick) begin
               next_s.shifter = s.serial_data_register;
               next_s.pend    = 1'b0;
               next_s.active  = 1'b1;
               next_s.bit_cnt = 4'h0;
               next_s.sclk    = 1'b0;
               next_s.sdat    = s.serial_data_register[SIA_BYTE_BITS-1];
            end
         end else if (tx_tick) begin
            if (!s.sclk) begin
               // Rising edge ends the bit period
               next_s.sclk    = 1'b1;
               next_s.shifter = {s.shifter[6:0], 1'b0};
               next_s.bit_cnt = s.bit_cnt + 4'h1;
               if (s.bit_cnt == SIA_LAST_BIT) begin
                  ser_event      = 1'b1;
                  next_s.bit_cnt = 4'h0;
                  if (s.pend) begin
                     next_s.shifter = s.serial_data_register;
                     next_s.pend    = 1'b0;
                  end else begin
                     next_s.active = 1'b0;
                  end
               end
            end else begin
               // Falling edge presents the next bit, held until the next fall
               next_s.sclk = 1'b0;
               next_s.sdat = s.shifter[SIA_BYTE_BITS-1];
            end
         end
      end else begin
         next_s.active = 1'b0;
         next_s.sclk   = 1'b1;
         next_s.pend   = 1'b0;
         if (rx_rise) begin
            rx_byte        = {s.shifter[6:0], s.sp_s2};
            next_s.shifter = rx_byte;
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == SIA_LAST_BIT) begin
               next_s.serial_data_register     = rx_byte;
               next_s.bit_cnt = 4'h0;
               ser_event      = 1'b1;
            end
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Timer A output and one-shot stop
      next_s.pulse = 1'b0;
      if (i_timer_a_underflow) begin
         next_s.tog   = ~s.tog;
         next_s.pulse = 1'b1;
         if (s.ctrl[SIA_CTRL_RUN]) begin
            next_s.ctrl[SIA_CTRL_START] = 1'b0;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Event collection
      events[SIA_SRC_TIMER_A] = i_timer_a_underflow;
      events[SIA_SRC_TIMER_B] = i_timer_b_underflow;
      events[SIA_SRC_ALARM]   = i_alarm;
      events[SIA_SRC_SERIAL]  = ser_event;
      events[SIA_SRC_FLAG]    = ~s.flg_s2 & s.flg_prev;

      ////////////////////////////////////////////////////////////////////////
      // Register reads; status clears but a same-cycle event survives
      next_s.rdata = 8'h00;
      if (i_rd) begin
         if (sia_hit(i_addr, SIA_ISM_OFFSET)) begin
            next_s.rdata = {s.ir, 2'b00, s.status};
            next_s.status = SIA_STAT_RESET;
         end else if (sia_hit(i_addr, SIA_CTRL_OFFSET)) begin
            next_s.rdata = s.ctrl & SIA_CTRL_STORE_MASK;
         end else if (sia_hit(i_addr, SIA_SDR_OFFSET)) begin
            next_s.rdata = s.serial_data_register;
         end
      end
      next_s.status = next_s.status | events;

      ////////////////////////////////////////////////////////////////////////
      // Register writes
      next_s.force_load = 1'b0;
      if (i_wr) begin
         if (sia_hit(i_addr, SIA_ISM_OFFSET)) begin
            if (i_wdata[SIA_ISM_SC_BIT]) begin
               next_s.mask = s.mask | i_wdata[4:0];
            end else begin
               next_s.mask = s.mask & ~i_wdata[4:0];
            end
         end else if (sia_hit(i_addr, SIA_CTRL_OFFSET)) begin
            next_s.ctrl       = i_wdata & SIA_CTRL_STORE_MASK;
            next_s.force_load = i_wdata[SIA_CTRL_LOAD];
            // Toggle output starts high whenever the timer is started
            if (i_wdata[SIA_CTRL_START] && !s.ctrl[SIA_CTRL_START]) begin
               next_s.tog = 1'b1;
            end
            // A direction change abandons any partial byte
            if (i_wdata[SIA_CTRL_DIR] != s.ctrl[SIA_CTRL_DIR]) begin
               next_s.bit_cnt = 4'h0;
               next_s.active  = 1'b0;
               next_s.pend    = 1'b0;
               next_s.sclk    = 1'b1;
            end
         end else if (sia_hit(i_addr, SIA_SDR_OFFSET)) begin
            next_s.serial_data_register = i_wdata;
            if (out_mode) begin
               next_s.pend = 1'b1;
            end
         end
      end

      // Summary bit follows enabled latched sources
      next_s.ir = |(next_s.status & next_s.mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s            <= '0;
         s.status     <= SIA_STAT_RESET;
         s.mask       <= SIA_MASK_RESET;
         s.ctrl       <= SIA_CTRL_RESET;
         s.serial_data_register        <= SIA_SDR_RESET;
         s.sclk       <= 1'b1;
         s.sdat       <= 1'b1;
         s.cnt_s1     <= 1'b1;
         s.cnt_s2     <= 1'b1;
         s.cnt_prev   <= 1'b1;
         s.flg_s1     <= 1'b1;
         s.flg_s2     <= 1'b1;
         s.flg_prev   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_rdata = s.rdata;
   assign o_irq_n = ~s.ir;

   // Open drain: pins only ever pull low, released level comes from pull-ups
   assign o_shift_count_pin    = 1'b0;
   assign o_shift_count_pin_oe = s.ctrl[SIA_CTRL_DIR] & ~s.sclk;
   assign o_serial_data_pin    = 1'b0;
   assign o_serial_data_pin_oe = s.ctrl[SIA_CTRL_DIR] & ~s.sdat;

   assign o_timer_a_run        = s.ctrl[SIA_CTRL_START];
   assign o_timer_a_one_shot   = s.ctrl[SIA_CTRL_RUN];
   assign o_timer_a_force_load = s.force_load;
   assign o_timer_a_count_pin  = s.ctrl[SIA_CTRL_CSRC];
   assign o_timer_a_pin_rise   = s.pin_rise;

   assign o_timer_output_route = s.ctrl[SIA_CTRL_ROUTE];
   assign o_port_b_line_six    = s.ctrl[SIA_CTRL_STYLE] ? s.tog : s.pulse;

endmodule // sia_ctrl

// [bench/sia_ctrl_monitor.sv]
// Checker of the serial, interrupt and timer A control ports.
// Assumes it is bound onto sia_ctrl with every port joined by name.
`timescale 1ns/1ps
module sia_ctrl_monitor
   import sia_pkg::*;
(
   // Clock, reset, register port
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // Events, pins, request
   input wire logic       i_timer_a_underflow,
   input wire logic       o_shift_count_pin,
   input wire logic       o_shift_count_pin_oe,
   input wire logic       o_serial_data_pin,
   input wire logic       o_serial_data_pin_oe,
   input wire logic       o_irq_n,
   // Timer A controls
   input wire logic       o_timer_a_run,
   input wire logic       o_timer_a_one_shot,
   input wire logic       o_timer_a_force_load,
   input wire logic       o_timer_a_count_pin,
   input wire logic       o_timer_output_route
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
////////////////////////////////////////////////////////////
   a_status_gap: assert property (i_rd && i_addr == SIA_ISM_OFFSET |=>
      o_rdata[6:5] == 2'b00) else $error("status gap bits set");
   a_irq_summary: assert property (i_rd && i_addr == SIA_ISM_OFFSET |=>
      o_rdata[7] == !$past(o_irq_n)) else $error("summary differs from request");
   a_pins_drain: assert property (!o_shift_count_pin && !o_serial_data_pin)
      else $error("pin driven high");
   a_load_strobe: assert property (o_timer_a_force_load ==
      $past(i_wr && i_addr == SIA_CTRL_OFFSET && i_wdata[4])) else $error("load pulse wrong");
   a_ctrl_store: assert property (i_wr && i_addr == SIA_CTRL_OFFSET |=>
      o_timer_a_run == $past(i_wdata[0]) && o_timer_output_route == $past(i_wdata[1])
      && o_timer_a_one_shot == $past(i_wdata[3]) && o_timer_a_count_pin == $past(i_wdata[5]))
      else $error("control bits not stored");
   a_oneshot_stop: assert property (o_timer_a_run && o_timer_a_one_shot
      && i_timer_a_underflow && !(i_wr && i_addr == SIA_CTRL_OFFSET) |=> !o_timer_a_run)
      else $error("one-shot did not stop");
   a_ctrl_zeros: assert property (i_rd && i_addr == SIA_CTRL_OFFSET |=>
      o_rdata[7] == 1'b0 && o_rdata[4] == 1'b0 && o_rdata[0] == $past(o_timer_a_run))
      else $error("control read wrong");
   a_clk_half: assert property ($changed(o_shift_count_pin_oe) |=>
      $stable(o_shift_count_pin_oe)) else $error("shift clock too fast");
   a_data_on_fall: assert property ($changed(o_serial_data_pin_oe) |->
      $rose(o_shift_count_pin_oe)) else $error("data moved off clock fall");
endmodule // sia_ctrl_monitor

// [bench/sia_far_dev.sv]
// Far shift device on the serial bus: master sender and slave receiver.
// Assumes the bench resolves both wires with a pull-up from all enables.
`timescale 1ns/1ps
module sia_far_dev #(
   parameter int HALF = 4
) (
   // Clock and wires
   input  wire logic       i_core_clk,
   input  wire logic       i_clk_wire,
   input  wire logic       i_data_wire,
   // Sender
   input  wire logic       i_tx_go,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_clk_oe = 1'b0,
   output logic            o_data_oe = 1'b0,
   output logic            o_tx_busy = 1'b0,
   // Receiver
   output logic      [7:0] o_rx_byte = 8'h00,
   output logic            o_rx_valid = 1'b0
);
   logic       clk_q = 1'b1;
   logic [7:0] sh = 8'h00;
   int         cnt = 0;
////////////////////////////////////////////////////////////
   // Data moves with the clock fall, so it is steady across the rise
   always @(posedge i_core_clk) begin
      if (i_tx_go) begin
         o_tx_busy <= 1'b1;
         for (int b = 7; b >= 0; b--) begin
            o_clk_oe  <= 1'b1;
            o_data_oe <= ~i_tx_byte[b];
            repeat (HALF) @(posedge i_core_clk);
            o_clk_oe <= 1'b0;
            repeat (HALF) @(posedge i_core_clk);
         end
         o_data_oe <= 1'b0;
         o_tx_busy <= 1'b0;
      end
   end
   // Own rises are ignored, else the sender would hear itself
   always @(posedge i_core_clk) begin
      clk_q      <= i_clk_wire;
      o_rx_valid <= 1'b0;
      if (!o_tx_busy && i_clk_wire && !clk_q) begin
         sh = {sh[6:0], i_data_wire};
         cnt++;
         if (cnt == 8) begin
            o_rx_byte  <= sh;
            o_rx_valid <= 1'b1;
            cnt = 0;
         end
      end
   end
endmodule // sia_far_dev

// [bench/sia_ctrl_tb.sv]
// Bench of sia_ctrl: register tasks, event pulses and a far shift device.
// Assumes sia_pkg offsets; wires are open drain with a pull-up.
`timescale 1ns/1ps
module sia_ctrl_tb;
   import sia_pkg::*;
   logic       i_core_clk, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_edge_flag_source = 1'b1;
   logic       go = 1'b0, ua_g = 1'b0, ua_en = 1'b0, rd_v = 1'b0, rx_v, far_busy;
   logic       far_clk_oe, far_data_oe, o_shift_count_pin, o_shift_count_pin_oe;
   logic       o_serial_data_pin, o_serial_data_pin_oe, o_irq_n, o_timer_a_run;
   logic       o_timer_a_one_shot, o_timer_a_force_load, o_timer_a_count_pin;
   logic       o_timer_a_pin_rise, o_timer_output_route, o_port_b_line_six;
   logic [2:0] ev_v = 3'b000;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, txb = 8'h00, b2, rx_b, rq[$], sq[$];
   int         n_mismatch = 0, n_checks = 0, n_rx = 0, cyc = 0, per = 2, ua_cnt = 0;
   integer     seed = 32'hdd6d5f79;
   wire        clk_wire  = ~(o_shift_count_pin_oe | far_clk_oe);
   wire        data_wire = ~(o_serial_data_pin_oe | far_data_oe);
   wire        ua = ev_v[0] | ua_g;
   sia_ctrl sia_ctrl_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_timer_a_underflow(ua), .i_timer_b_underflow(ev_v[1]), .i_alarm(ev_v[2]),
      .i_edge_flag_source, .i_shift_count_pin(clk_wire), .o_shift_count_pin,
      .o_shift_count_pin_oe, .i_serial_data_pin(data_wire), .o_serial_data_pin,
      .o_serial_data_pin_oe, .o_irq_n, .o_timer_a_run, .o_timer_a_one_shot,
      .o_timer_a_force_load, .o_timer_a_count_pin, .o_timer_a_pin_rise,
      .o_timer_output_route, .o_port_b_line_six);
   sia_far_dev sia_far_dev_i (.i_core_clk, .i_clk_wire(clk_wire), .i_data_wire(data_wire),
      .i_tx_go(go), .i_tx_byte(txb), .o_clk_oe(far_clk_oe), .o_data_oe(far_data_oe),
      .o_tx_busy(far_busy), .o_rx_byte(rx_b), .o_rx_valid(rx_v));
////////////////////////////////////////////////////////////
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: level %b expected %b", $time, got, exp);
      end
   endtask
   // Bus tasks end just past the edge, so outputs have settled
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      rq.push_back(exp);
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
   endtask
   task automatic pulse(input logic [2:0] m);
      @(posedge i_core_clk);
      ev_v <= m;
      @(posedge i_core_clk);
      ev_v <= 3'b000;
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      rd_v   <= i_rd;
      ua_cnt <= (ua_cnt >= per - 1) ? 0 : ua_cnt + 1;
      ua_g   <= ua_en && ua_cnt == 0;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   always @(negedge i_core_clk) begin
      if (rd_v && rq.size() > 0) cmp_byte(o_rdata, rq.pop_front());
      if (rx_v && sq.size() > 0) begin
         cmp_byte(rx_b, sq.pop_front());
         n_rx++;
      end
   end
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd(SIA_CTRL_OFFSET, 8'h00);
      rd(SIA_ISM_OFFSET, 8'h00);
      rd(4'h3, 8'h00);
      cmp_bit(o_irq_n, 1'b1);
      wr(SIA_CTRL_OFFSET, 8'hff);
      rd(SIA_CTRL_OFFSET, 8'h6f);
      wr(SIA_CTRL_OFFSET, 8'h00);
      wr(SIA_CTRL_OFFSET, 8'h0b);
      pulse(3'b001);
      cmp_bit(o_port_b_line_six, 1'b1);
      rd(SIA_CTRL_OFFSET, 8'h0a);
      wr(SIA_CTRL_OFFSET, 8'h07);
      cmp_bit(o_port_b_line_six, 1'b1);
      pulse(3'b001);
      cmp_bit(o_port_b_line_six, 1'b0);
      rd(SIA_ISM_OFFSET, 8'h01);
      wr(SIA_ISM_OFFSET, 8'he2);
      pulse(3'b010);
      @(posedge i_core_clk);
      #1;
      cmp_bit(o_irq_n, 1'b0);
      rd(SIA_ISM_OFFSET, 8'h82);
      cmp_bit(o_irq_n, 1'b1);
      wr(SIA_ISM_OFFSET, 8'h02);
      pulse(3'b110);
      rd(SIA_ISM_OFFSET, 8'h06);
      i_edge_flag_source <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      i_edge_flag_source <= 1'b1;
      rd(SIA_ISM_OFFSET, 8'h10);
      wr(SIA_CTRL_OFFSET, 8'h00);
      txb = 8'($random(seed));
      go  = 1'b1;
      @(posedge i_core_clk);
      go <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      while (far_busy) @(posedge i_core_clk);
      repeat (4) @(posedge i_core_clk);
      rd(SIA_SDR_OFFSET, txb);
      rd(SIA_ISM_OFFSET, 8'h08);
      per   = 2 + ($unsigned($random(seed)) % 3);
      ua_en <= 1'b1;
      wr(SIA_CTRL_OFFSET, 8'h41);
      txb = 8'($random(seed));
      b2  = 8'($random(seed));
      sq.push_back(txb);
      wr(SIA_SDR_OFFSET, txb);
      while (!o_shift_count_pin_oe) @(posedge i_core_clk);
      sq.push_back(b2);
      wr(SIA_SDR_OFFSET, b2);
      while (n_rx < 2) @(posedge i_core_clk);
      repeat (12) @(posedge i_core_clk);
      #1;
      cmp_bit(clk_wire, 1'b1);
      cmp_bit(data_wire, b2[0]);
      ua_en <= 1'b0;
      rd(SIA_ISM_OFFSET, 8'h09);
      close_out();
   end
endmodule // sia_ctrl_tb
bind sia_ctrl sia_ctrl_monitor sia_ctrl_monitor_i (.i_core_clk, .i_rst, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_timer_a_underflow, .o_shift_count_pin, .o_shift_count_pin_oe,
   .o_serial_data_pin, .o_serial_data_pin_oe, .o_irq_n, .o_timer_a_run, .o_timer_a_one_shot,
   .o_timer_a_force_load, .o_timer_a_count_pin, .o_timer_output_route);
